// ==== rtl/mpc_map.vh ====
// Register offsets, field positions, reset values and timing counts of the pin control block
`ifndef MPC_MAP_VH
`define MPC_MAP_VH

// Register offsets, byte addressed
`define MPC_ADDR_W 8
`define MPC_DATA_W 8
`define MPC_REG_CFG 8'h40
`define MPC_REG_IRQ_STAT 8'h41
`define MPC_REG_IRQ_CLR 8'h42
`define MPC_REG_IRQ_EN 8'h43
`define MPC_REG_CHAS_CLR 8'h46
`define MPC_REG_MODE 8'h47
`define MPC_REG_PIN_STAT 8'h48
`define MPC_REG_DAC 8'h49

// Configuration and chassis clear register fields
`define MPC_CFG_INT_EN 1
`define MPC_CFG_RST_GO 4
`define MPC_CFG_CI_CLR 6
`define MPC_CHAS_CI_CLR 7

// Mode register fields
`define MPC_MODE_THERMAL_ALARM_PIN_IN 0
`define MPC_MODE_FAN1 1
`define MPC_MODE_FAN2 2

// Interrupt status bits
`define MPC_IRQ_W 4
`define MPC_IRQ_INTRUSION 0
`define MPC_IRQ_THERMAL_ALARM_PIN_IN 1
`define MPC_IRQ_RST_DONE 2
`define MPC_IRQ_CI_DONE 3

// Reset values
`define MPC_CFG_RST 8'h00
`define MPC_MODE_RST 8'h00
`define MPC_DAC_RST 8'h00
`define MPC_IRQ_EN_RST 4'h0

// Address select codes for the two low address bits
`define MPC_ADDR_LOW 2'h0
`define MPC_ADDR_OPEN 2'h1
`define MPC_ADDR_HIGH 2'h2

// Connectivity tree width
`define MPC_TREE_W 8

// Timing: clock rate in kHz, pulse lengths in ms, derived cycle counts
`define MPC_CLK_KHZ 200000
`define MPC_RST_PULSE_MS 45
`define MPC_CI_PULSE_MS 20
`define MPC_RST_PULSE_CYC (`MPC_RST_PULSE_MS * `MPC_CLK_KHZ)
`define MPC_CI_PULSE_CYC (`MPC_CI_PULSE_MS * `MPC_CLK_KHZ)
`define MPC_CNT_W 24

`endif

// ==== rtl/mpc_pulse.v ====
// Fixed length pulse timer used by the open-drain pin drivers
`timescale 1ns/1ps
`include "mpc_map.vh"

module mpc_pulse #(
  parameter [`MPC_CNT_W-1:0] CYCLES = 24'h000010
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clr,
  input wire start,
  output reg busy_r,
  output reg done_r
);

  reg [`MPC_CNT_W-1:0] cnt_r;

  // Busy for exactly CYCLES clocks; a start while busy is ignored
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {`MPC_CNT_W{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (clr) begin
      cnt_r <= {`MPC_CNT_W{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && start) begin
        cnt_r <= CYCLES - 24'h000001;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == {`MPC_CNT_W{1'b0}}) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 24'h000001;
        end
      end
    end
  end

endmodule

// ==== rtl/mpc_top.v ====
// Auxiliary pin control of the hardware monitor: intrusion, interrupt, reset, address, tree
`timescale 1ns/1ps
`include "mpc_map.vh"


module mpc_top #(
  parameter [`MPC_CNT_W-1:0] RST_PULSE_CYC = `MPC_RST_PULSE_CYC,
  parameter [`MPC_CNT_W-1:0] CI_PULSE_CYC = `MPC_CI_PULSE_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  // Register port
  input wire [`MPC_ADDR_W-1:0] reg_addr,
  input wire [`MPC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`MPC_DATA_W-1:0] reg_rdata_r,
  output reg irq_r,
  // Chassis intrusion pin
  input wire intrusion_sense_pin_i,
  output wire intrusion_sense_pin_o,
  output reg intrusion_sense_pin_oe_n_r,
  // Interrupt request pin
  output wire int_req_pin_o,
  output reg int_req_pin_oe_n_r,
  // Master reset pin
  input wire reset_pin_i,
  output wire reset_pin_o,
  output reg reset_pin_oe_n_r,
  // Address select pad comparators and tree output
  input wire addr_sel_hi_i,
  input wire addr_sel_lo_i,
  output reg address_select_tree_out_r,
  output reg address_select_tree_out_oe_n_r,
  output reg [1:0] addr_lsb_r,
  // Tree test enable and analog output control
  input wire tree_test_enable_in,
  input wire [`MPC_TREE_W-1:0] tree_in,
  output reg tree_mode_r,
  output reg dac_en_r,
  output reg [`MPC_DATA_W-1:0] dac_code_r,
  // Thermal alarm pin
  input wire thermal_alarm_pin_i,
  output wire thermal_alarm_pin_o,
  output reg thermal_alarm_pin_oe_n_r,
  input wire temp_irq_i,
  output reg fan_ctrl_irq_r,
  // Programmable fan or analog inputs
  input wire tach_or_analog_in_1,
  input wire tach_or_analog_in_2,
  output reg [1:0] fan_mode_r,
  output reg [1:0] tach_level_r
);

  // Open-drain drivers only ever pull low
  assign intrusion_sense_pin_o = 1'b0;
  assign int_req_pin_o = 1'b0;
  assign reset_pin_o = 1'b0;
  assign thermal_alarm_pin_o = 1'b0;

  reg [`MPC_DATA_W-1:0] cfg_r;
  reg [`MPC_DATA_W-1:0] mode_r;
  reg [`MPC_IRQ_W-1:0] irq_stat_r;
  reg [`MPC_IRQ_W-1:0] irq_en_r;
  reg intrusion_prev_r;
  reg thermal_alarm_pin_prev_r;
  reg ci_go_r;
  reg rst_go_r;
  reg [`MPC_IRQ_W-1:0] irq_stat_nxt;
  reg [`MPC_DATA_W-1:0] rdata_nxt;

  wire ci_busy;
  wire ci_done;
  wire rst_busy;
  wire rst_done;
  wire ext_rst;
  wire wr_cfg;
  wire wr_chas;
  wire [1:0] addr_code;
  wire thermal_alarm_pin_in_mode;
  wire [`MPC_IRQ_W-1:0] irq_evt;

  // Three-level pad decode: both comparators idle means the pin floats
  function [1:0] addr_decode;
    input hi;
    input lo;
    begin
      if (hi) begin
        addr_decode = `MPC_ADDR_HIGH;
      end else if (lo) begin
        addr_decode = `MPC_ADDR_LOW;
      end else begin
        addr_decode = `MPC_ADDR_OPEN;
      end
    end
  endfunction

  // Chained NAND over all tree inputs; a pin changes the result only while the chain before it is high
  function tree_nand;
    input [`MPC_TREE_W-1:0] vec;
    integer i;
    reg t;
    begin
      t = 1'b1;
      for (i = 0; i < `MPC_TREE_W; i = i + 1) begin
        t = ~(t & vec[i]);
      end
      tree_nand = t;
    end
  endfunction

  // Own drive of the reset pin is masked so the pulse cannot wipe the registers or the clear timer;
  // the enable lags busy by one cycle, so it must be masked as well
  assign ext_rst = !reset_pin_i && reset_pin_oe_n_r && !rst_busy && !rst_go_r;

  assign wr_cfg = reg_wr && (reg_addr == `MPC_REG_CFG);
  assign wr_chas = reg_wr && (reg_addr == `MPC_REG_CHAS_CLR);
  assign addr_code = addr_decode(addr_sel_hi_i, addr_sel_lo_i);
  assign thermal_alarm_pin_in_mode = mode_r[`MPC_MODE_THERMAL_ALARM_PIN_IN];

  // Event sources; intrusion is the rising edge of the high level from the outside latch
  assign irq_evt[`MPC_IRQ_INTRUSION] = intrusion_sense_pin_i && !intrusion_prev_r
    && !ci_busy;
  assign irq_evt[`MPC_IRQ_THERMAL_ALARM_PIN_IN] = thermal_alarm_pin_in_mode && !thermal_alarm_pin_i && thermal_alarm_pin_prev_r;
  assign irq_evt[`MPC_IRQ_RST_DONE] = rst_done;
  assign irq_evt[`MPC_IRQ_CI_DONE] = ci_done;

  // Pulse timers for the two open-drain clearing and reset drivers
  mpc_pulse #(
    .CYCLES(CI_PULSE_CYC)
  ) u_ci_pulse (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(ext_rst),
    .start(ci_go_r),
    .busy_r(ci_busy),
    .done_r(ci_done)
  );

  mpc_pulse #(
    .CYCLES(RST_PULSE_CYC)
  ) u_rst_pulse (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(1'b0),
    .start(rst_go_r),
    .busy_r(rst_busy),
    .done_r(rst_done)
  );

  // Sticky status: a new event wins over a clear in the same cycle
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (reg_wr && (reg_addr == `MPC_REG_IRQ_CLR)) begin
      irq_stat_nxt = irq_stat_nxt & ~reg_wdata[`MPC_IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_evt;
  end

  // Read mux; command bits read back as their pulse being active
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `MPC_REG_CFG: begin
        rdata_nxt = cfg_r;
        rdata_nxt[`MPC_CFG_RST_GO] = rst_busy;
        rdata_nxt[`MPC_CFG_CI_CLR] = ci_busy;
      end
      `MPC_REG_IRQ_STAT: begin
        rdata_nxt = {4'h0, irq_stat_r};
      end
      `MPC_REG_IRQ_EN: begin
        rdata_nxt = {4'h0, irq_en_r};
      end
      `MPC_REG_CHAS_CLR: begin
        rdata_nxt[`MPC_CHAS_CI_CLR] = ci_busy;
      end
      `MPC_REG_MODE: begin
        rdata_nxt = mode_r;
      end
      `MPC_REG_PIN_STAT: begin
        rdata_nxt = {1'b0, fan_ctrl_irq_r, tree_mode_r, thermal_alarm_pin_i,
          reset_pin_i, intrusion_sense_pin_i, addr_lsb_r};
      end
      `MPC_REG_DAC: begin
        rdata_nxt = dac_code_r;
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // Software registers; an external reset pin low returns every one to default
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `MPC_CFG_RST;
      mode_r <= `MPC_MODE_RST;
      dac_code_r <= `MPC_DAC_RST;
      irq_en_r <= `MPC_IRQ_EN_RST;
      irq_stat_r <= 4'h0;
      ci_go_r <= 1'b0;
      rst_go_r <= 1'b0;
    end else if (ext_rst) begin
      cfg_r <= `MPC_CFG_RST;
      mode_r <= `MPC_MODE_RST;
      dac_code_r <= `MPC_DAC_RST;
      irq_en_r <= `MPC_IRQ_EN_RST;
      irq_stat_r <= 4'h0;
      ci_go_r <= 1'b0;
      rst_go_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      // Command bits are one-shot strobes into the pulse timers
      ci_go_r <= (wr_cfg && reg_wdata[`MPC_CFG_CI_CLR])
        || (wr_chas && reg_wdata[`MPC_CHAS_CI_CLR]);
      rst_go_r <= wr_cfg && reg_wdata[`MPC_CFG_RST_GO];
      if (wr_cfg) begin
        cfg_r <= reg_wdata & 8'haf;
      end
      if (reg_wr && (reg_addr == `MPC_REG_MODE)) begin
        mode_r <= reg_wdata & 8'h07;
      end
      if (reg_wr && (reg_addr == `MPC_REG_IRQ_EN)) begin
        irq_en_r <= reg_wdata[`MPC_IRQ_W-1:0];
      end
      if (reg_wr && (reg_addr == `MPC_REG_DAC)) begin
        dac_code_r <= reg_wdata;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  // Interrupt outputs follow the registered status one cycle later
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
      int_req_pin_oe_n_r <= 1'b1;
    end else begin
      irq_r <= |(irq_stat_r & irq_en_r);
      // Pin pulls low only when enabled; otherwise left to the pull-up
      int_req_pin_oe_n_r <= !(cfg_r[`MPC_CFG_INT_EN]
        && |(irq_stat_r & irq_en_r));
    end
  end

  // Open-drain drive of the intrusion and reset pins during their pulses
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      intrusion_sense_pin_oe_n_r <= 1'b1;
      reset_pin_oe_n_r <= 1'b1;
    end else begin
      intrusion_sense_pin_oe_n_r <= !ci_busy;
      reset_pin_oe_n_r <= !rst_busy;
    end
  end

  // Edge history of the sensed pins
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      intrusion_prev_r <= 1'b0;
      thermal_alarm_pin_prev_r <= 1'b1;
    end else begin
      intrusion_prev_r <= intrusion_sense_pin_i;
      thermal_alarm_pin_prev_r <= thermal_alarm_pin_i;
    end
  end

  // Tree mode turns the address pin into an output and stops the analog output
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tree_mode_r <= 1'b0;
      dac_en_r <= 1'b0;
      address_select_tree_out_r <= 1'b1;
      address_select_tree_out_oe_n_r <= 1'b1;
      addr_lsb_r <= `MPC_ADDR_OPEN;
    end else begin
      tree_mode_r <= tree_test_enable_in;
      dac_en_r <= !tree_test_enable_in;
      address_select_tree_out_r <= tree_nand(tree_in);
      address_select_tree_out_oe_n_r <= !tree_test_enable_in;
      // Address is frozen during tree test since the pin is then ours
      if (!tree_test_enable_in && address_select_tree_out_oe_n_r) begin
        addr_lsb_r <= addr_code;
      end
    end
  end

  // Thermal pin: temperature alarm out, or fan control alarm in
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      thermal_alarm_pin_oe_n_r <= 1'b1;
      fan_ctrl_irq_r <= 1'b0;
    end else if (ext_rst) begin
      thermal_alarm_pin_oe_n_r <= 1'b1;
      fan_ctrl_irq_r <= 1'b0;
    end else begin
      thermal_alarm_pin_oe_n_r <= !(!thermal_alarm_pin_in_mode && temp_irq_i);
      fan_ctrl_irq_r <= thermal_alarm_pin_in_mode && !thermal_alarm_pin_i;
    end
  end

  // Programmable inputs: tach levels pass only in fan mode, analog mode masks them
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fan_mode_r <= 2'h0;
      tach_level_r <= 2'h0;
    end else begin
      fan_mode_r <= {mode_r[`MPC_MODE_FAN2], mode_r[`MPC_MODE_FAN1]};
      tach_level_r[0] <= mode_r[`MPC_MODE_FAN1] && tach_or_analog_in_1;
      tach_level_r[1] <= mode_r[`MPC_MODE_FAN2] && tach_or_analog_in_2;
    end
  end

endmodule

// ==== sim/mpc_board_model.sv ====
// Board side model: intrusion latch, pull-ups, address strap, board drivers
`timescale 1ns/1ps

module mpc_board_model (
  input wire clk_sys,
  input wire tamper,
  input wire board_rst_n,
  input wire thermal_alarm_pin_drive_n,
  input wire [1:0] strap,
  input wire intrusion_sense_pin_oe_n_r,
  input wire reset_pin_oe_n_r,
  input wire thermal_alarm_pin_oe_n_r,
  input wire address_select_tree_out_r,
  input wire address_select_tree_out_oe_n_r,
  output wire intrusion_sense_pin_i,
  output wire reset_pin_i,
  output wire thermal_alarm_pin_i,
  output wire addr_sel_hi_i,
  output wire addr_sel_lo_i
);
  reg latch_r = 1'b0;

  // Latch catches tampering; the device pull-down clears it
  always @(posedge clk_sys) begin
    if (!intrusion_sense_pin_oe_n_r)
      latch_r <= 1'b0;
    else if (tamper)
      latch_r <= 1'b1;
  end

  // Wired levels: pulled-up lines go low if anyone pulls
  assign intrusion_sense_pin_i = latch_r & intrusion_sense_pin_oe_n_r;
  assign reset_pin_i = board_rst_n & reset_pin_oe_n_r;
  assign thermal_alarm_pin_i = thermal_alarm_pin_drive_n & thermal_alarm_pin_oe_n_r;
  // Strap codes 0 low, 1 open, 2 high; in tree mode the pad shows the device
  assign addr_sel_hi_i = address_select_tree_out_oe_n_r ? strap == 2'h2 : address_select_tree_out_r;
  assign addr_sel_lo_i = address_select_tree_out_oe_n_r ? strap == 2'h0 : !address_select_tree_out_r;
endmodule

// ==== sim/mpc_top_asserts.sv ====
// Concurrent checks on the ports of the pin control block
`timescale 1ns/1ps
`include "mpc_map.vh"

module mpc_top_asserts #(
  parameter [`MPC_CNT_W-1:0] RST_PULSE_CYC = 24'h000010,
  parameter [`MPC_CNT_W-1:0] CI_PULSE_CYC = 24'h000008
) (
  input wire clk_sys,
  input wire rst_n,
  input wire reset_pin_i,
  input wire intrusion_sense_pin_o,
  input wire intrusion_sense_pin_oe_n_r,
  input wire int_req_pin_o,
  input wire int_req_pin_oe_n_r,
  input wire irq_r,
  input wire reset_pin_oe_n_r,
  input wire addr_sel_hi_i,
  input wire addr_sel_lo_i,
  input wire [1:0] addr_lsb_r,
  input wire tree_test_enable_in,
  input wire tree_mode_r,
  input wire dac_en_r,
  input wire thermal_alarm_pin_i,
  input wire thermal_alarm_pin_oe_n_r,
  input wire temp_irq_i,
  input wire fan_ctrl_irq_r
);
  reg [`MPC_CNT_W-1:0] rst_cnt_r;
  reg [`MPC_CNT_W-1:0] ci_cnt_r;
  reg ci_ab_r;

  // Low-time counters; the pulses are far too long for a repetition
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= 24'h0;
      ci_cnt_r <= 24'h0;
      ci_ab_r <= 1'b0;
    end else begin
      rst_cnt_r <= reset_pin_oe_n_r ? 24'h0 : rst_cnt_r + 24'h1;
      ci_cnt_r <= intrusion_sense_pin_oe_n_r ? 24'h0 : ci_cnt_r + 24'h1;
      // A board reset may cut the clear pulse short, so skip that one
      ci_ab_r <= !intrusion_sense_pin_oe_n_r & (ci_ab_r | !reset_pin_i);
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_pins_only_low: assert property (!int_req_pin_o && !intrusion_sense_pin_o)
    else $error("Open-drain pin driven high");
  chk_int_needs_irq: assert property (!int_req_pin_oe_n_r |-> irq_r)
    else $error("Interrupt pin pulled without pending event");
  chk_rst_pulse_len: assert property ($rose(reset_pin_oe_n_r) |-> rst_cnt_r == RST_PULSE_CYC)
    else $error("Reset pulse length wrong");
  chk_ci_pulse_len: assert property ($rose(intrusion_sense_pin_oe_n_r) && !ci_ab_r
    |-> ci_cnt_r == CI_PULSE_CYC)
    else $error("Intrusion clear pulse length wrong");
  chk_addr_sel_high: assert property (!tree_test_enable_in && addr_sel_hi_i
    |=> addr_lsb_r == `MPC_ADDR_HIGH)
    else $error("Address bits wrong for high strap");
  chk_addr_sel_open: assert property (!tree_test_enable_in && !addr_sel_hi_i && !addr_sel_lo_i
    |=> addr_lsb_r == `MPC_ADDR_OPEN)
    else $error("Address bits wrong for open strap");
  chk_tree_mode_on: assert property (tree_test_enable_in |=> tree_mode_r && !dac_en_r)
    else $error("Tree mode not entered");
  chk_dac_mode_on: assert property (!tree_test_enable_in |=> !tree_mode_r && dac_en_r)
    else $error("Analog output not enabled");
  chk_thermal_alarm_pin_out_src: assert property (!thermal_alarm_pin_oe_n_r |-> $past(temp_irq_i))
    else $error("Thermal pin pulled without temperature event");
  chk_fan_irq_src: assert property (fan_ctrl_irq_r |-> $past(!thermal_alarm_pin_i))
    else $error("Fan control event without low thermal pin");
  chk_ext_reset_irq: assert property (!reset_pin_i && reset_pin_oe_n_r ##1 !reset_pin_i
    |=> !irq_r)
    else $error("Interrupt survives board reset");

  cov_rst_pulse: cover property ($rose(reset_pin_oe_n_r));
  cov_ci_pulse: cover property ($rose(intrusion_sense_pin_oe_n_r));
  cov_int_pin: cover property (!int_req_pin_oe_n_r);
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`include "mpc_map.vh"

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_top;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg tree_test_enable_in = 1'b0;
  reg temp_irq_i = 1'b0;
  reg tach_or_analog_in_1 = 1'b0;
  reg tach_or_analog_in_2 = 1'b0;
  reg tamper = 1'b0;
  reg board_rst_n = 1'b1;
  reg thermal_alarm_pin_drive_n = 1'b1;
  reg [1:0] strap = 2'h1;
  wire [7:0] reg_rdata_r;
  wire [7:0] dac_code_r;
  wire [1:0] addr_lsb_r;
  wire [1:0] fan_mode_r;
  wire [1:0] tach_level_r;
  wire irq_r, intrusion_sense_pin_i, intrusion_sense_pin_o, intrusion_sense_pin_oe_n_r;
  wire int_req_pin_o, int_req_pin_oe_n_r, reset_pin_i, reset_pin_o, reset_pin_oe_n_r;
  wire addr_sel_hi_i, addr_sel_lo_i, address_select_tree_out_r, address_select_tree_out_oe_n_r;
  wire tree_mode_r, dac_en_r, thermal_alarm_pin_i, thermal_alarm_pin_o;
  wire thermal_alarm_pin_oe_n_r, fan_ctrl_irq_r;
  wire int_pin = int_req_pin_oe_n_r ? 1'b1 : int_req_pin_o;
  int miscompares = 0;
  int n_checks = 0;
  int i;

  always #2.5 clk_sys = ~clk_sys;

  mpc_top #(.RST_PULSE_CYC(24'h000010), .CI_PULSE_CYC(24'h000008)) u_mpc_top (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .irq_r,
    .intrusion_sense_pin_i, .intrusion_sense_pin_o, .intrusion_sense_pin_oe_n_r,
    .int_req_pin_o, .int_req_pin_oe_n_r, .reset_pin_i, .reset_pin_o, .reset_pin_oe_n_r,
    .addr_sel_hi_i, .addr_sel_lo_i, .address_select_tree_out_r,
    .address_select_tree_out_oe_n_r, .addr_lsb_r, .tree_test_enable_in,
    .tree_in(8'h5a), .tree_mode_r, .dac_en_r, .dac_code_r, .thermal_alarm_pin_i,
    .thermal_alarm_pin_o, .thermal_alarm_pin_oe_n_r, .temp_irq_i, .fan_ctrl_irq_r,
    .tach_or_analog_in_1, .tach_or_analog_in_2, .fan_mode_r, .tach_level_r);

  mpc_board_model u_mpc_board_model (
    .clk_sys, .tamper, .board_rst_n, .thermal_alarm_pin_drive_n, .strap, .intrusion_sense_pin_oe_n_r,
    .reset_pin_oe_n_r, .thermal_alarm_pin_oe_n_r, .address_select_tree_out_r,
    .address_select_tree_out_oe_n_r, .intrusion_sense_pin_i, .reset_pin_i,
    .thermal_alarm_pin_i, .addr_sel_hi_i, .addr_sel_lo_i);

  // Register write: one strobe cycle
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Register read: data stands only in the cycle after the strobe
  task rd(input [7:0] a, input [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK($sformatf("reg %h", a), e, reg_rdata_r)
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task final_report;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    final_report;
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    wt(1);
    // Defaults and an unmapped read
    `CHK("int_oe_n", 1'b1, int_req_pin_oe_n_r)
    rd(8'h40, 8'h00);
    rd(8'h43, 8'h00);
    rd(8'h50, 8'h00);
    // Strap levels low, open, high seen in pin status
    for (i = 0; i < 3; i++) begin
      strap <= i[1:0];
      wt(3);
      rd(8'h48, {6'h06, i[1:0]});
    end
    // Event pending but pin disabled, then enabled
    wr(8'h43, 8'h0f);
    tamper <= 1'b1;
    wt(2);
    tamper <= 1'b0;
    wt(3);
    rd(8'h41, 8'h01);
    `CHK("int_oe_n", 1'b1, int_req_pin_oe_n_r)
    wr(8'h40, 8'h02);
    wt(2);
    `CHK("int_pin", 1'b0, int_pin)
    // Latch clear by both command bits
    for (i = 0; i < 2; i++) begin
      tamper <= 1'b1;
      wt(2);
      tamper <= 1'b0;
      if (i == 0)
        wr(8'h46, 8'h80);
      else
        wr(8'h40, 8'h42);
      wt(3);
      `CHK("ci_pin", 1'b0, intrusion_sense_pin_i)
      wt(12);
      rd(8'h41, 8'h09);
      wr(8'h42, 8'h0f);
      wt(2);
      `CHK("int_pin", 1'b1, int_pin)
    end
    // Own reset pulse must not wipe the registers
    wr(8'h40, 8'h12);
    wt(3);
    `CHK("rst_pin", 1'b0, reset_pin_i)
    wt(20);
    rd(8'h41, 8'h04);
    rd(8'h40, 8'h02);
    // Board reset returns registers to defaults
    wr(8'h49, 8'ha5);
    rd(8'h49, 8'ha5);
    `CHK("dac_code", 8'ha5, dac_code_r)
    board_rst_n <= 1'b0;
    wt(3);
    board_rst_n <= 1'b1;
    wt(1);
    rd(8'h49, 8'h00);
    rd(8'h40, 8'h00);
    `CHK("irq", 1'b0, irq_r)
    // Thermal pin as input, then as output
    wr(8'h43, 8'h02);
    wr(8'h47, 8'h01);
    thermal_alarm_pin_drive_n <= 1'b0;
    wt(3);
    `CHK("fan_irq", 1'b1, fan_ctrl_irq_r)
    rd(8'h41, 8'h02);
    thermal_alarm_pin_drive_n <= 1'b1;
    wr(8'h47, 8'h00);
    temp_irq_i <= 1'b1;
    wt(3);
    `CHK("thermal_alarm_pin_pin", 1'b0, thermal_alarm_pin_i)
    temp_irq_i <= 1'b0;
    // Both programmable inputs as tachometers
    wr(8'h47, 8'h06);
    tach_or_analog_in_1 <= 1'b1;
    tach_or_analog_in_2 <= 1'b1;
    wt(3);
    `CHK("fan_mode", 2'h3, fan_mode_r)
    `CHK("tach", 2'h3, tach_level_r)
    // Tree test mode in and out
    tree_test_enable_in <= 1'b1;
    wt(3);
    `CHK("tree_oe_n", 1'b0, address_select_tree_out_oe_n_r)
    `CHK("tree_out", 1'b1, address_select_tree_out_r)
    `CHK("tree_mode", 1'b1, tree_mode_r)
    `CHK("dac_en", 1'b0, dac_en_r)
    tree_test_enable_in <= 1'b0;
    wt(3);
    `CHK("dac_en", 1'b1, dac_en_r)
    final_report;
  end
endmodule

bind mpc_top mpc_top_asserts #(.RST_PULSE_CYC(RST_PULSE_CYC), .CI_PULSE_CYC(CI_PULSE_CYC))
  u_mpc_top_asserts (.clk_sys, .rst_n, .reset_pin_i, .intrusion_sense_pin_o,
  .intrusion_sense_pin_oe_n_r, .int_req_pin_o, .int_req_pin_oe_n_r, .irq_r,
  .reset_pin_oe_n_r, .addr_sel_hi_i, .addr_sel_lo_i, .addr_lsb_r, .tree_test_enable_in,
  .tree_mode_r, .dac_en_r, .thermal_alarm_pin_i, .thermal_alarm_pin_oe_n_r, .temp_irq_i,
  .fan_ctrl_irq_r);
